// [pkg/motion_guard_pkg.sv]
// Shared constants and carrier types of the axis limit and status monitor.
// Assumes a 250 MHz card clock and a 32-bit classic Wishbone register bus.
package motion_guard_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int NET_CYCLE_NS = 888000;
  localparam int NET_CYCLE_CLKS = NET_CYCLE_NS / CLK_PERIOD_NS;
  localparam int NUM_AXES = 12;
  localparam int CH_PER_AXIS = 3;
  // Global register byte offsets.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SERVO_OFS = 12'h004;
  localparam logic [11:0] STOP_OFS = 12'h008;
  localparam logic [11:0] MIO_LO_OFS = 12'h00c;
  localparam logic [11:0] MIO_HI_OFS = 12'h010;
  localparam logic [11:0] MDI_LO_OFS = 12'h014;
  localparam logic [11:0] MDI_HI_OFS = 12'h018;
  // Per-axis blocks sit at 0x200 + axis * 0x20.
  localparam logic [2:0] AX_REGION = 3'h1;
  localparam logic [2:0] AX_CFG_IDX = 3'h0;
  localparam logic [2:0] AX_PLIM_IDX = 3'h1;
  localparam logic [2:0] AX_MLIM_IDX = 3'h2;
  localparam logic [2:0] AX_COND_IDX = 3'h3;
  localparam logic [2:0] AX_MOVE_IDX = 3'h4;
  localparam logic [2:0] AX_FBV_IDX = 3'h5;
  localparam logic [2:0] AX_CMDV_IDX = 3'h6;
  // Control register fields and reset values of the control and axis config registers.
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_EMG_POL = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [5:0] CFG_RST = 6'h15;
  // Axis condition word bits.
  localparam int AS_NOT_IN_CTRL = 0;
  localparam int AS_ALARM = 1;
  // Movement state word bits.
  localparam int MS_READY = 0;
  localparam int MS_MOVING = 1;
  localparam int MS_HOMING = 2;
  localparam int MS_VCHG = 3;
  localparam int MS_PCHG = 4;
  localparam int MS_MEL = 5;
  localparam int MS_PEL = 6;
  localparam int MS_ORG = 7;
  localparam int MS_EMG = 8;
  localparam int MS_PSOFT = 9;
  localparam int MS_MSOFT = 10;
  localparam int MS_INDEX = 11;
  localparam int MS_STOP_END = 12;
  localparam int MS_STOP_RUN = 13;
  localparam int MS_INTERLOCK = 14;
  localparam logic [31:0] MOVE_FAIL = 32'h8000_0000;

  typedef struct packed {
    logic soft_en;
    logic org_pol;
    logic mel_decel;
    logic mel_pol;
    logic pel_decel;
    logic pel_pol;
  } axis_cfg_t;

  typedef struct packed {
    logic found;
    logic alarm;
    logic ready;
    logic servo;
  } drv_stat_t;

  typedef struct packed {
    logic moving;
    logic dir_minus;
    logic homing;
    logic vchg;
    logic pchg;
    logic interlock;
  } plan_stat_t;

  typedef struct packed {
    logic idx;
    logic origin_input;
    logic minus_end_limit;
    logic plus_end_limit;
  } axis_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_END = 3'b100
  } stop_state_t;
endpackage : motion_guard_pkg

// [test/motion_guard_bench.sv]
// Self-checking bench of the limit and status monitor, two axes.
// Assumes the far-side model and a short network cycle of ten clocks.
`timescale 1ns/1ns
module motion_guard_bench
  import motion_guard_pkg::*;
;
  localparam int NA = 2;
  localparam int NC = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  axis_pins_t [NA-1:0] sw = '0;
  logic emg_sw = 1'b0;
  logic [NA-1:0][31:0] pos = '0;
  logic [NA-1:0] alarm = '0;
  logic [NA-1:0] go = '0;
  axis_pins_t [NA-1:0] pins;
  logic emg_pin;
  logic [NA-1:0][31:0] fbp;
  logic [NA-1:0][31:0] fbv;
  logic [NA-1:0][31:0] cmdv;
  drv_stat_t [NA-1:0] drv;
  plan_stat_t [NA-1:0] plan;
  logic tick;
  logic irq;
  logic [NA-1:0] son;
  logic [NA-1:0] stn;
  logic [NA-1:0] std;
  logic [NA-1:0] alp;
  logic [NA-1:0] alm;
  logic [NA-1:0] origin_input;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;

  always #2 clk_i = ~clk_i;

  servo_side_model #(.N(NA), .MISSING(1)) i_far (.clk_i(clk_i), .rst_i(rst_i), .sw_i(sw),
    .emg_i(emg_sw), .pos_i(pos), .alarm_i(alarm), .go_i(go), .tick_i(tick), .pins_o(pins),
    .emg_o(emg_pin), .fb_pos_o(fbp), .fb_vel_o(fbv), .cmd_vel_o(cmdv), .drv_o(drv), .plan_o(plan));

  motion_guard #(.N(NA), .NET_CLKS(NC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins),
    .emg_pin_i(emg_pin), .fb_pos_i(fbp), .fb_vel_i(fbv), .drv_i(drv), .cmd_vel_i(cmdv),
    .plan_i(plan), .net_tick_o(tick), .servo_on_o(son), .stop_now_o(stn), .stop_decel_o(std),
    .allow_plus_o(alp), .allow_minus_o(alm), .origin_hit_o(origin_input), .irq_o(irq));

  task automatic stop_test();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [11:0] ax(input int a, input logic [2:0] idx);
    return 12'h200 + 12'(a) * 12'h020 + {7'h00, idx, 2'h0};
  endfunction : ax

  // One classic cycle; read data is taken at the edge that shows ack.
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("Error ack expected 1 seen %b", wb_ack_o);
      stop_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rchk(input string nm, input logic [11:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  task automatic t_regs();
    int k;
    rchk("ctrl", CTRL_OFS, 32'h2);
    rchk("cfg0", ax(0, AX_CFG_IDX), 32'h15);
    rchk("cond1", ax(1, AX_COND_IDX), 32'h1);
    rchk("move1", ax(1, AX_MOVE_IDX), MOVE_FAIL);
    chk("allow1", 32'h0, {alp[1], alm[1]});
    rchk("cond0", ax(0, AX_COND_IDX), 32'h0);
    rchk("move0", ax(0, AX_MOVE_IDX), 32'h1);
    bus(1'b1, 12'h100, 32'hffff_ffff);
    rchk("unmapped", 12'h100, 32'h0);
    bus(1'b1, SERVO_OFS, 32'h3);
    chk("servo_on", 32'h3, son);
    k = 0;
    repeat (5 * NC) begin
      @(posedge clk_i);
      if (tick === 1'b1) k++;
    end
    chk("ticks", 32'd5, k);
  endtask : t_regs

  task automatic t_soft();
    bus(1'b1, ax(0, AX_PLIM_IDX), 32'd100);
    bus(1'b1, ax(0, AX_MLIM_IDX), 32'hffff_ff9c);
    bus(1'b1, ax(0, AX_CFG_IDX), 32'h35);
    rchk("plim", ax(0, AX_PLIM_IDX), 32'd100);
    rchk("mlim", ax(0, AX_MLIM_IDX), 32'hffff_ff9c);
    rchk("soft_en", ax(0, AX_CFG_IDX), 32'h35);
    pos[0] <= 32'd100;
    repeat (3 * NC) @(posedge clk_i);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("at_bound", 32'h0, rd[MS_PSOFT]);
    pos[0] <= 32'd101;
    repeat (3 * NC) @(posedge clk_i);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("psoft", 32'h1, rd[MS_PSOFT]);
    chk("psoft_allow", 32'h1, {alp[0], alm[0]});
    pos[0] <= 32'hffff_ff9b;
    repeat (3 * NC) @(posedge clk_i);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("msoft", 32'h1, rd[MS_MSOFT]);
    pos[0] <= 32'h0;
    bus(1'b1, ax(0, AX_CFG_IDX), 32'h15);
  endtask : t_soft

  task automatic t_limit();
    sw[0] <= '{plus_end_limit: 1'b1, origin_input: 1'b1, default: 1'b0};
    repeat (8) @(posedge clk_i);
    chk("pel_allow", 32'h1, {alp[0], alm[0]});
    chk("org_hit", 32'h1, origin_input[0]);
    rchk("raw", MDI_LO_OFS, 32'h5);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("pel_bit", 32'h1, rd[MS_PEL]);
    chk("org_bit", 32'h1, rd[MS_ORG]);
    sw[0] <= '{minus_end_limit: 1'b1, default: 1'b0};
    go[0] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("mel_ignored", 32'h0, stn[0]);
    chk("org_clear", 32'h0, origin_input[0]);
    sw[0].plus_end_limit <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("pel_stop", 32'h1, stn[0]);
    chk("no_irq", 32'h0, irq);
    bus(1'b1, ax(0, AX_CFG_IDX), 32'h17);
    repeat (3) @(posedge clk_i);
    chk("pel_decel", 32'h2, {std[0], stn[0]});
    bus(1'b1, MIO_LO_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("mode_gp", 32'h0, {std[0], stn[0]});
    rchk("raw_gp", MDI_LO_OFS, 32'h3);
    go[0] <= 1'b0;
    sw[0] <= '0;
    bus(1'b1, MIO_LO_OFS, 32'h0);
    bus(1'b1, ax(0, AX_CFG_IDX), 32'h14);
    repeat (8) @(posedge clk_i);
    chk("pel_low_act", 32'h1, {alp[0], alm[0]});
    bus(1'b1, ax(0, AX_CFG_IDX), 32'h15);
  endtask : t_limit

  task automatic t_emg();
    int k;
    bus(1'b1, CTRL_OFS, 32'h3);
    emg_sw <= 1'b1;
    k = 0;
    repeat (12) begin
      @(posedge clk_i);
      if (irq === 1'b1) k++;
    end
    chk("emg_irq", 32'd1, k);
    chk("emg_stop", 32'h3, stn);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("emg_bit", 32'h1, rd[MS_EMG]);
    emg_sw <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("emg_clear", 32'h0, stn);
  endtask : t_emg

  task automatic t_stop();
    go[0] <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("moving", 32'h2, rd[1:0]);
    bus(1'b1, STOP_OFS, 32'h1);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("stop_run", 32'h1, rd[MS_STOP_RUN]);
    chk("stop_decel", 32'h1, std[0]);
    go[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, ax(0, AX_MOVE_IDX), 32'h0);
    chk("stop_end", 32'h1, {rd[MS_STOP_RUN], rd[MS_STOP_END]});
  endtask : t_stop

  task automatic t_alarm();
    alarm[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk("cond_alarm", ax(0, AX_COND_IDX), 32'h2);
    chk("alarm_allow", 32'h0, {alp[0], alm[0]});
    rchk("move_fail", ax(0, AX_MOVE_IDX), MOVE_FAIL);
    alarm[0] <= 1'b0;
  endtask : t_alarm

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_regs();
    t_soft();
    t_limit();
    t_emg();
    t_stop();
    t_alarm();
    stop_test();
  end
endmodule : motion_guard_bench

// [test/servo_side_model.sv]
// Far-side model: servo drivers, planner state and switch levels.
// Assumes the bench sets switch, position, alarm and motion levels.
`timescale 1ns/1ns
module servo_side_model
  import motion_guard_pkg::*;
#(
  parameter int N = 2,
  parameter int MISSING = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls.
  input wire axis_pins_t [N-1:0] sw_i,
  input wire logic emg_i,
  input wire logic [N-1:0][31:0] pos_i,
  input wire logic [N-1:0] alarm_i,
  input wire logic [N-1:0] go_i,
  input wire logic tick_i,
  // Far-side levels.
  output axis_pins_t [N-1:0] pins_o,
  output logic emg_o,
  output logic [N-1:0][31:0] fb_pos_o,
  output logic [N-1:0][31:0] fb_vel_o,
  output logic [N-1:0][31:0] cmd_vel_o,
  output drv_stat_t [N-1:0] drv_o,
  output plan_stat_t [N-1:0] plan_o
);
  logic [31:0] vel_q;

  // Switch levels reach the pins one cycle after the bench sets them.
  always_ff @(posedge clk_i) begin
    pins_o <= sw_i;
    emg_o <= emg_i;
    fb_pos_o <= pos_i;
    if (rst_i) begin
      vel_q <= 32'h0;
    end else if (tick_i) begin
      vel_q <= vel_q + 32'h1;
    end
  end

  // One axis has no driver on the network; the others report ready and servo on.
  always_comb begin
    for (int a = 0; a < N; a++) begin
      drv_o[a] = '{found: (a != MISSING), alarm: alarm_i[a], ready: 1'b1, servo: 1'b1};
      plan_o[a] = '{moving: go_i[a], default: 1'b0};
      fb_vel_o[a] = vel_q;
      cmd_vel_o[a] = vel_q + 32'h1;
    end
  end
endmodule : servo_side_model

// [verilog/axis_guard.sv]
// Stop decisions and status words of one axis.
// Assumes synchronised pins, a one-cycle network tick and registered settings.
`timescale 1ns/1ns
module axis_guard
  import motion_guard_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Card-wide events.
  input wire logic tick_i,
  input wire logic emg_act_i,
  input wire logic stop_cmd_i,
  // Settings.
  input wire axis_cfg_t cfg_i,
  input wire logic [2:0] gp_i,
  input wire logic signed [31:0] plim_i,
  input wire logic signed [31:0] mlim_i,
  // Live axis state.
  input wire axis_pins_t pins_i,
  input wire logic signed [31:0] fb_pos_i,
  input wire drv_stat_t drv_i,
  input wire plan_stat_t plan_i,
  // Results.
  output logic stop_now_o,
  output logic stop_decel_o,
  output logic allow_plus_o,
  output logic allow_minus_o,
  output logic origin_hit_o,
  output logic limit_rise_o,
  output logic [3:0] cond_o,
  output logic [31:0] move_o
);
  logic pel_lvl, mel_lvl, org_lvl, pel_act, mel_act, hit_p, hit_m;
  logic blocked, idle, run_p, run_m, now_d, decel_d, ap_d, am_d, rise_d;
  logic psoft_d, psoft_q, msoft_d, msoft_q, pel_q, mel_q;
  logic [3:0] cond_d;
  logic [31:0] move_d;
  stop_state_t st_d, st_q;

  assign pel_lvl = pins_i.plus_end_limit == cfg_i.pel_pol;
  assign mel_lvl = pins_i.minus_end_limit == cfg_i.mel_pol;
  assign org_lvl = pins_i.origin_input == cfg_i.org_pol;

  always_comb begin
    pel_act = pel_lvl && !gp_i[0];
    mel_act = mel_lvl && !gp_i[1];
    psoft_d = psoft_q;
    msoft_d = msoft_q;
    if (!cfg_i.soft_en) begin
      psoft_d = 1'b0;
      msoft_d = 1'b0;
    end else if (tick_i) begin
      psoft_d = fb_pos_i > plim_i;
      msoft_d = fb_pos_i < mlim_i;
    end
    hit_p = pel_act || psoft_q;
    hit_m = mel_act || msoft_q;
    cond_d = {!drv_i.servo, !drv_i.ready, drv_i.alarm, !drv_i.found};
    blocked = cond_d[AS_NOT_IN_CTRL] || cond_d[AS_ALARM];
    idle = !plan_i.moving && !plan_i.homing;
    // A move only sees the limit ahead of it; the one behind is ignored.
    run_p = plan_i.moving && !plan_i.dir_minus && hit_p;
    run_m = plan_i.moving && plan_i.dir_minus && hit_m;
    now_d = emg_act_i || (!idle && blocked) || (run_p && !cfg_i.pel_decel) || (run_m && !cfg_i.mel_decel);
    decel_d = !now_d && (run_p || run_m || st_q == ST_RUN);
    ap_d = idle && !hit_p && !blocked && !emg_act_i;
    am_d = idle && !hit_m && !blocked && !emg_act_i;
    rise_d = (pel_act && !pel_q) || (mel_act && !mel_q);
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (stop_cmd_i) st_d = ST_RUN;
      end
      ST_RUN: begin
        if (idle) st_d = ST_END;
      end
      ST_END: begin
        if (stop_cmd_i) st_d = ST_RUN;
        else if (!idle) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    move_d = '0;
    if (cond_d != 4'h0) begin
      move_d = MOVE_FAIL;
    end else begin
      move_d[MS_READY] = idle;
      move_d[MS_MOVING] = plan_i.moving && !plan_i.homing;
      move_d[MS_HOMING] = plan_i.homing;
      move_d[MS_VCHG] = plan_i.vchg;
      move_d[MS_PCHG] = plan_i.pchg;
      move_d[MS_MEL] = mel_lvl;
      move_d[MS_PEL] = pel_lvl;
      move_d[MS_ORG] = org_lvl;
      move_d[MS_EMG] = emg_act_i;
      move_d[MS_PSOFT] = psoft_q;
      move_d[MS_MSOFT] = msoft_q;
      move_d[MS_INDEX] = pins_i.idx;
      move_d[MS_STOP_END] = st_d == ST_END;
      move_d[MS_STOP_RUN] = st_d == ST_RUN;
      move_d[MS_INTERLOCK] = plan_i.interlock;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psoft_q <= 1'b0;
      msoft_q <= 1'b0;
      pel_q <= 1'b0;
      mel_q <= 1'b0;
      st_q <= ST_IDLE;
      stop_now_o <= 1'b0;
      stop_decel_o <= 1'b0;
      allow_plus_o <= 1'b0;
      allow_minus_o <= 1'b0;
      origin_hit_o <= 1'b0;
      limit_rise_o <= 1'b0;
      cond_o <= 4'h1;
      move_o <= MOVE_FAIL;
    end else begin
      psoft_q <= psoft_d;
      msoft_q <= msoft_d;
      pel_q <= pel_act;
      mel_q <= mel_act;
      st_q <= st_d;
      stop_now_o <= now_d;
      stop_decel_o <= decel_d;
      allow_plus_o <= ap_d;
      allow_minus_o <= am_d;
      origin_hit_o <= org_lvl && !gp_i[2];
      limit_rise_o <= rise_d;
      cond_o <= cond_d;
      move_o <= move_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_launch;
    stop_cmd_i && st_q == ST_IDLE && cond_d == 4'h0;
  endsequence
  sequence s_running;
    move_o[MS_STOP_RUN] && !move_o[MS_STOP_END];
  endsequence
  a_stop_running: assert property (s_launch |=> s_running)
    else $error("stop launch not reported as running");
  a_plus_block: assert property (hit_p |=> !allow_plus_o)
    else $error("plus move allowed at plus limit");
  a_query_fail: assert property ((|cond_o) |-> move_o == MOVE_FAIL)
    else $error("movement word valid while axis not ready");
  a_soft_trip: assert property (tick_i && cfg_i.soft_en && fb_pos_i > plim_i |=> psoft_q)
    else $error("plus soft bound not caught at tick");
endmodule : axis_guard

// [verilog/input_sync.sv]
// Three-stage synchroniser with agreement filter for switch inputs.
// Assumes asynchronous pin levels; output moves once stages two and three agree.
`timescale 1ns/1ns
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and filtered levels.
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_d;

  always_comb begin
    lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_o);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_o <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_o <= lvl_d;
    end
  end
endmodule : input_sync

// [verilog/motion_guard.sv]
// Card-level limit, emergency and status monitor for all axes.
// Assumes a classic Wishbone master, servo data refreshed by the network
// controller, and a trajectory planner that obeys the stop and allow outputs.
`timescale 1ns/1ns
module motion_guard
  import motion_guard_pkg::*;
#(
  parameter int N = NUM_AXES,
  parameter int NET_CLKS = NET_CYCLE_CLKS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Switch pins.
  input wire axis_pins_t [N-1:0] pins_i,
  input wire logic emg_pin_i,
  // Servo network data.
  input wire logic [N-1:0][31:0] fb_pos_i,
  input wire logic [N-1:0][31:0] fb_vel_i,
  input wire drv_stat_t [N-1:0] drv_i,
  // Trajectory planner.
  input wire logic [N-1:0][31:0] cmd_vel_i,
  input wire plan_stat_t [N-1:0] plan_i,
  // Controls to planner and drivers.
  output logic net_tick_o,
  output logic [N-1:0] servo_on_o,
  output logic [N-1:0] stop_now_o,
  output logic [N-1:0] stop_decel_o,
  output logic [N-1:0] allow_plus_o,
  output logic [N-1:0] allow_minus_o,
  output logic [N-1:0] origin_hit_o,
  output logic irq_o
);
  localparam int NCH = N * CH_PER_AXIS;
  localparam int CW = $clog2(NET_CLKS + 1);
  localparam int SW = 4 * N + 1;

  logic [SW-1:0] sy_lvl;
  axis_pins_t [N-1:0] pin_lvl;
  logic emg_act, emg_prev_q, irq_d;
  logic [CW-1:0] cnt_d, cnt_q;
  logic tick_d;
  logic [N-1:0] lim_rise;
  logic [N-1:0][3:0] cond;
  logic [N-1:0][31:0] move;
  logic [NCH-1:0] motion_input_channel;
  logic [63:0] mdi64, mio64;
  logic [31:0] mdi_lo;

  // Bus signals.
  logic req, wr, ack_d, ax_hit;
  logic [3:0] ax;
  logic [2:0] ax_reg;
  logic [31:0] rd_d, wv;

  // Register state.
  logic [1:0] ctrl_d, ctrl_q;
  logic [N-1:0] servo_d, stop_d, stop_q;
  logic [NCH-1:0] mio_d, mio_q;
  logic [N-1:0][5:0] cfg_d, cfg_q;
  logic [N-1:0][31:0] plim_d, plim_q, mlim_d, mlim_q;
  logic [N-1:0][31:0] fbv_d, fbv_q, cmdv_d, cmdv_q;

  input_sync #(
    .W(SW)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({emg_pin_i, pins_i}),
    .lvl_o(sy_lvl)
  );

  assign pin_lvl = sy_lvl[SW-2:0];
  assign emg_act = sy_lvl[SW-1] == ctrl_q[CTRL_EMG_POL];

  // Channel 3a is plus, 3a+1 minus, 3a+2 origin of axis a.
  always_comb begin
    motion_input_channel = '0;
    for (int a = 0; a < N; a++) begin
      motion_input_channel[CH_PER_AXIS*a] = pin_lvl[a].plus_end_limit;
      motion_input_channel[CH_PER_AXIS*a+1] = pin_lvl[a].minus_end_limit;
      motion_input_channel[CH_PER_AXIS*a+2] = pin_lvl[a].origin_input;
    end
  end

  assign mdi64 = 64'(motion_input_channel);
  assign mio64 = 64'(mio_q);
  assign mdi_lo = mdi64[31:0];

  // Network cycle timer.
  always_comb begin
    tick_d = cnt_q == CW'(NET_CLKS - 1);
    cnt_d = tick_d ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      net_tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      net_tick_o <= tick_d;
    end
  end

  generate
    for (genvar a = 0; a < N; a++) begin : g_axis
      axis_guard u_axis (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(net_tick_o),
        .emg_act_i(emg_act),
        .stop_cmd_i(stop_q[a]),
        .cfg_i(axis_cfg_t'(cfg_q[a])),
        .gp_i(mio_q[CH_PER_AXIS*a +: CH_PER_AXIS]),
        .plim_i(plim_q[a]),
        .mlim_i(mlim_q[a]),
        .pins_i(pin_lvl[a]),
        .fb_pos_i(fb_pos_i[a]),
        .drv_i(drv_i[a]),
        .plan_i(plan_i[a]),
        .stop_now_o(stop_now_o[a]),
        .stop_decel_o(stop_decel_o[a]),
        .allow_plus_o(allow_plus_o[a]),
        .allow_minus_o(allow_minus_o[a]),
        .origin_hit_o(origin_hit_o[a]),
        .limit_rise_o(lim_rise[a]),
        .cond_o(cond[a]),
        .move_o(move[a])
      );
    end
  endgenerate

  // Bus decode; one request is taken per ack.
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr = req && wb_we_i;
    ack_d = req;
    ax = wb_adr_i[8:5];
    ax_reg = wb_adr_i[4:2];
    ax_hit = wb_adr_i[11:9] == AX_REGION && 32'(ax) < N;
  end

  // Read value; unmapped words read as zero.
  always_comb begin
    rd_d = '0;
    if (ax_hit) begin
      case (ax_reg)
        AX_CFG_IDX: rd_d[5:0] = cfg_q[ax];
        AX_PLIM_IDX: rd_d = plim_q[ax];
        AX_MLIM_IDX: rd_d = mlim_q[ax];
        AX_COND_IDX: rd_d[3:0] = cond[ax];
        AX_MOVE_IDX: rd_d = move[ax];
        AX_FBV_IDX: rd_d = fbv_q[ax];
        AX_CMDV_IDX: rd_d = cmdv_q[ax];
        default: rd_d = '0;
      endcase
    end else begin
      case (wb_adr_i)
        CTRL_OFS: rd_d[1:0] = ctrl_q;
        SERVO_OFS: rd_d = 32'(servo_on_o);
        MIO_LO_OFS: rd_d = mio64[31:0];
        MIO_HI_OFS: rd_d = mio64[63:32];
        MDI_LO_OFS: rd_d = mdi_lo;
        MDI_HI_OFS: rd_d = mdi64[63:32];
        default: rd_d = '0;
      endcase
    end
  end

  // Byte lanes merge new data into the current word.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wv[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : rd_d[8*b +: 8];
    end
  end

  // Register writes and per-cycle velocity capture.
  always_comb begin
    ctrl_d = ctrl_q;
    servo_d = servo_on_o;
    mio_d = mio_q;
    cfg_d = cfg_q;
    plim_d = plim_q;
    mlim_d = mlim_q;
    stop_d = '0;
    fbv_d = fbv_q;
    cmdv_d = cmdv_q;
    if (net_tick_o) begin
      fbv_d = fb_vel_i;
      cmdv_d = cmd_vel_i;
    end
    if (wr && ax_hit) begin
      case (ax_reg)
        AX_CFG_IDX: cfg_d[ax] = wv[5:0];
        AX_PLIM_IDX: plim_d[ax] = wv;
        AX_MLIM_IDX: mlim_d[ax] = wv;
        default: cfg_d = cfg_q;
      endcase
    end else if (wr) begin
      case (wb_adr_i)
        CTRL_OFS: ctrl_d = wv[1:0];
        SERVO_OFS: servo_d = wv[N-1:0];
        STOP_OFS: stop_d = wv[N-1:0];
        MIO_LO_OFS: mio_d = NCH'({mio64[63:32], wv});
        MIO_HI_OFS: mio_d = NCH'({wv, mio64[31:0]});
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  // Interrupt request on a new limit or emergency activation.
  always_comb begin
    irq_d = ctrl_q[CTRL_IRQ_EN] && ((emg_act && !emg_prev_q) || (|lim_rise));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_q <= CTRL_RST;
      servo_on_o <= '0;
      stop_q <= '0;
      mio_q <= '0;
      cfg_q <= {N{CFG_RST}};
      plim_q <= '0;
      mlim_q <= '0;
      fbv_q <= '0;
      cmdv_q <= '0;
      emg_prev_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= req ? rd_d : '0;
      ctrl_q <= ctrl_d;
      servo_on_o <= servo_d;
      stop_q <= stop_d;
      mio_q <= mio_d;
      cfg_q <= cfg_d;
      plim_q <= plim_d;
      mlim_q <= mlim_d;
      fbv_q <= fbv_d;
      cmdv_q <= cmdv_d;
      emg_prev_q <= emg_act;
      irq_o <= irq_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_emg_stops_all: assert property (emg_act |=> &stop_now_o)
    else $error("emergency did not stop every axis");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_irq_on_emg: assert property (ctrl_q[CTRL_IRQ_EN] && emg_act && !emg_prev_q |=> irq_o)
    else $error("emergency activation raised no interrupt");
  a_irq_quiet: assert property (!ctrl_q[CTRL_IRQ_EN] |=> !irq_o)
    else $error("interrupt raised while disabled");
  a_vel_latch: assert property (net_tick_o |=> fbv_q == $past(fb_vel_i) && cmdv_q == $past(cmd_vel_i))
    else $error("velocities not captured at network tick");
  a_tick_gap: assert property (net_tick_o |=> !net_tick_o [*2])
    else $error("network ticks too close");
  a_bound_write: assert property (wr && ax_hit && ax_reg == AX_PLIM_IDX |=> plim_q[$past(ax)] == $past(wv))
    else $error("plus soft bound write lost");
  a_mdi_raw: assert property (req && !wb_we_i && !ax_hit && wb_adr_i == MDI_LO_OFS
    |=> wb_dat_o == $past(mdi_lo))
    else $error("raw channel read mismatch");
endmodule : motion_guard
